// file: design/sdl_pkg.sv
// Constants, register map and carrier types of the synthesizer control block
// Behaviour
// [RL1] Crystal oscillator runs while its enable bit is set; on at power-up; off when CE low.
// [RL2] With an external reference, host clears the oscillator bit and drives the second pin.
// [RL3] Reference output divider divides by even ratios 2 to 30, 50:50 duty.
// [RL4] Reference output divider defaults to divide-by-eight after power-up.
// [RL5] Divide field of zero turns the divided reference output off.
// [RL6] 3-bit counter divides reference by 1 to 7 to make the comparison clock.
// [RL7] Reference counter ratio resets to one.
// [RL8] 3-bit select field routes an internal signal onto the status output.
// [RL9] Status output shows regulator-ready by default after power-up.
// [RL10] Host waits for regulator-ready high (about 50 us) before programming.
// [RL11] Digital lock goes high after five comparisons with error below 15 ns.
// [RL12] Digital lock stays high until a 25 ns error is seen.
// [RL13] Analog lock is open-drain: high when locked, with narrow low pulses.
// [RL14] CE low shuts regulators and clears every configuration register.
// [RL15] Host holds CE high and waits for the regulator before any write.
// [RL16] Feedback divider: 8-bit integer counter plus 15-bit sigma-delta fraction.
// [RL17] Integer feedback ratio is never below 31.
// [RL18] Largest feedback ratio is 255 plus 32767/32768.
// [RL19] Oscillator output is halved for transmit carrier and receive LO.
// [RL20] Host sets the 2-bit oscillator adjust field for the wanted band.
// [RL21] Oscillator is powered while the synthesizer enable bit is set.
// [RL22] Low-band bit adds a further divide-by-two stage.
// [RL23] Host keeps the 4-bit oscillator bias field at 0xA or above.
// [RL24] Output frequency equals comparison rate times (integer + fraction/32768).
package sdl_pkg;
  // Register byte offsets
  localparam logic [3:0] SDL_OFS_CTRL0  = 4'h0;
  localparam logic [3:0] SDL_OFS_CTRL1  = 4'h4;
  localparam logic [3:0] SDL_OFS_FBDIV  = 4'h8;
  localparam logic [3:0] SDL_OFS_STATUS = 4'hC;
  // Reset values
  localparam logic [3:0] SDL_RST_REFOUT = 4'h4;   // Half-ratio 4, divide-by-8
  localparam logic [2:0] SDL_RST_RDIV   = 3'h1;
  localparam logic [2:0] SDL_RST_MUXSEL = 3'h0;
  localparam logic [7:0] SDL_INT_MIN    = 8'h1F;  // 31
  localparam logic [7:0] SDL_RST_INT    = 8'h1F;
  // Lock thresholds in ns and comparison count
  localparam logic [7:0] SDL_LOCK_SET_NS = 8'h0F; // 15 ns
  localparam logic [7:0] SDL_LOCK_CLR_NS = 8'h19; // 25 ns
  localparam logic [2:0] SDL_LOCK_COUNT  = 3'h5;
  // Regulator settle time
  localparam int SDL_CLK_MHZ       = 40;
  localparam int SDL_REG_SETTLE_US = 50;
  localparam int SDL_REG_SETTLE_CY = SDL_REG_SETTLE_US * SDL_CLK_MHZ;
  // Status mux selections
  typedef enum logic [2:0] {
    SDL_MUX_REGRDY = 3'h0, SDL_MUX_DLOCK = 3'h1, SDL_MUX_ALOCK = 3'h2,
    SDL_MUX_PFD = 3'h3, SDL_MUX_FBCARRY = 3'h4, SDL_MUX_ZERO = 3'h5
  } sdl_mux_t;
  // Software configuration
  typedef struct packed {
    logic       synth_enable_bit;
    logic [2:0] status_mux_select_field;
    logic       xtal_osc_enable_bit;
    logic [3:0] ref_out_divide_field;
    logic [2:0] ref_count_field;
    logic       low_band_halver_bit;
    logic [1:0] osc_band_adjust_field;
    logic [3:0] osc_bias_field;
    logic [7:0] fb_int_field;
    logic [14:0] fb_frac_field;
  } sdl_cfg_t;
  // Oscillator controls to analog
  typedef struct packed {
    logic       osc_power;
    logic [2:0] lo_divide;
    logic [1:0] band_adjust;
    logic [3:0] bias;
  } sdl_vco_t;
endpackage

// file: design/sdl_top.sv
// Synthesizer digital control: registers, dividers, lock detect, status mux
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module sdl_top
  import sdl_pkg::*;
#(
  parameter int REG_SETTLE_CY = SDL_REG_SETTLE_CY
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Chip enable pin
  input  wire logic        chip_enable,
  // Phase detector measurement, one per comparison
  input  wire logic        pfd_err_valid,
  input  wire logic [7:0]  pfd_err_ns,
  // Outputs
  output logic             divided_ref_output,
  output logic             pfd_ref_tick,
  output logic [8:0]       fb_divide_now,
  output logic             fb_carry,
  output logic             status_mux_output_pin,
  output logic             digital_lock,
  output logic             alock_o,
  output logic             alock_oe,
  output logic             osc_running,
  output logic             regulator_ready,
  output sdl_vco_t         vco_ctrl
);

  //----------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------
  // Byte-lane merge for writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  //----------------------------------------------------------------
  // Chip enable sync and regulator
  //----------------------------------------------------------------
  logic        ce_meta_r;
  logic        ce_r;
  logic [15:0] settle_r;
  logic [15:0] settle_nxt;
  logic        regrdy_nxt;

  // Two stages since CE is a pin
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ce_meta_r <= 1'b0;
      ce_r      <= 1'b0;
    end else begin
      ce_meta_r <= chip_enable;
      ce_r      <= ce_meta_r;
    end
  end

  // Regulator comes up a fixed time after CE rises
  assign settle_nxt = !ce_r ? 16'h0000 :
                      (regulator_ready ? settle_r : settle_r + 16'h0001);
  assign regrdy_nxt = ce_r && (regulator_ready || (settle_r >= 16'(REG_SETTLE_CY - 1)));

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      settle_r        <= 16'h0000;
      regulator_ready <= 1'b0;
    end else begin
      settle_r        <= settle_nxt;
      regulator_ready <= regrdy_nxt;
    end
  end

  //----------------------------------------------------------------
  // Register bus
  //----------------------------------------------------------------
  sdl_cfg_t    cfg_r;
  sdl_cfg_t    cfg_nxt;
  sdl_cfg_t    cfg_dflt;
  logic [31:0] ctrl0_rd;
  logic [31:0] ctrl1_rd;
  logic [31:0] fbdiv_rd;
  logic [31:0] status_rd;
  logic [31:0] ctrl0_w;
  logic [31:0] ctrl1_w;
  logic [31:0] fbdiv_w;
  logic        bus_req;
  logic        wr_en;
  logic [31:0] rd_mux;

  assign cfg_dflt = '{synth_enable_bit: 1'b0, status_mux_select_field: SDL_RST_MUXSEL,
                      xtal_osc_enable_bit: 1'b1, ref_out_divide_field: SDL_RST_REFOUT,
                      ref_count_field: SDL_RST_RDIV, low_band_halver_bit: 1'b0,
                      osc_band_adjust_field: 2'h0, osc_bias_field: 4'h0,
                      fb_int_field: SDL_RST_INT, fb_frac_field: 15'h0000};

  // Register images as software sees them
  assign ctrl0_rd  = {28'h0000000, cfg_r.status_mux_select_field, cfg_r.synth_enable_bit};
  assign ctrl1_rd  = {16'h0000, cfg_r.osc_bias_field, cfg_r.osc_band_adjust_field,
                      cfg_r.low_band_halver_bit, cfg_r.xtal_osc_enable_bit,
                      1'b0, cfg_r.ref_count_field, cfg_r.ref_out_divide_field};
  assign fbdiv_rd  = {9'h000, cfg_r.fb_int_field, cfg_r.fb_frac_field};
  assign status_rd = {28'h0000000, osc_running, alock_oe, digital_lock, regulator_ready};

  assign ctrl0_w = lane_merge(ctrl0_rd, wb_dat_i, wb_sel_i);
  assign ctrl1_w = lane_merge(ctrl1_rd, wb_dat_i, wb_sel_i);
  assign fbdiv_w = lane_merge(fbdiv_rd, wb_dat_i, wb_sel_i);

  // Writes land only once the interface regulator is up
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en   = bus_req && wb_we_i && regulator_ready; // see [RL15]

  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_en) begin
      case (wb_adr_i)
        SDL_OFS_CTRL0: begin
          cfg_nxt.synth_enable_bit        = ctrl0_w[0];
          cfg_nxt.status_mux_select_field = ctrl0_w[3:1]; // see [RL8]
        end
        SDL_OFS_CTRL1: begin
          cfg_nxt.ref_out_divide_field  = ctrl1_w[3:0];
          cfg_nxt.ref_count_field       = ctrl1_w[6:4];
          cfg_nxt.xtal_osc_enable_bit   = ctrl1_w[8];
          cfg_nxt.low_band_halver_bit   = ctrl1_w[9];
          cfg_nxt.osc_band_adjust_field = ctrl1_w[11:10];
          cfg_nxt.osc_bias_field        = ctrl1_w[15:12];
        end
        SDL_OFS_FBDIV: begin
          cfg_nxt.fb_frac_field = fbdiv_w[14:0]; // see [RL16]
          // Pulse-swallow floor; values below are raised to it
          cfg_nxt.fb_int_field  = (fbdiv_w[22:15] < SDL_INT_MIN) ?
                                  SDL_INT_MIN : fbdiv_w[22:15]; // see [RL17]
        end
        default: begin
          cfg_nxt = cfg_r;
        end
      endcase
    end
    // Power-down erases all programmed state
    if (!ce_r) begin
      cfg_nxt = cfg_dflt; // see [RL14]
    end
  end

  assign rd_mux = (wb_adr_i == SDL_OFS_CTRL0)  ? ctrl0_rd :
                  (wb_adr_i == SDL_OFS_CTRL1)  ? ctrl1_rd :
                  (wb_adr_i == SDL_OFS_FBDIV)  ? fbdiv_rd :
                  (wb_adr_i == SDL_OFS_STATUS) ? status_rd : 32'h00000000;

  // Defaults at reset: osc on, div-8, R=1, mux regulator-ready
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= '{synth_enable_bit: 1'b0, status_mux_select_field: SDL_RST_MUXSEL,
                 xtal_osc_enable_bit: 1'b1, ref_out_divide_field: SDL_RST_REFOUT,
                 ref_count_field: SDL_RST_RDIV, low_band_halver_bit: 1'b0,
                 osc_band_adjust_field: 2'h0, osc_bias_field: 4'h0,
                 fb_int_field: SDL_RST_INT, fb_frac_field: 15'h0000}; // see [RL4] [RL7] [RL9]
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // One-cycle registered ack; unmapped reads return zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : wb_dat_o;
    end
  end

  //----------------------------------------------------------------
  // Reference oscillator and output divider
  //----------------------------------------------------------------
  logic [3:0] refdiv_cnt_r;
  logic [3:0] refdiv_cnt_nxt;
  logic       refdiv_wrap;
  logic       refout_nxt;

  assign osc_running = cfg_r.xtal_osc_enable_bit && ce_r; // see [RL1]

  // Half period of N clocks gives an even ratio 2N, duty 50:50
  assign refdiv_wrap    = (refdiv_cnt_r >= cfg_r.ref_out_divide_field - 4'h1);
  assign refdiv_cnt_nxt = (!osc_running || refdiv_wrap) ? 4'h0 : refdiv_cnt_r + 4'h1;
  assign refout_nxt     = (!osc_running || cfg_r.ref_out_divide_field == 4'h0) ? 1'b0 :
                          (refdiv_wrap ? !divided_ref_output : divided_ref_output); // see [RL3] [RL5]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      refdiv_cnt_r       <= 4'h0;
      divided_ref_output <= 1'b0;
    end else begin
      refdiv_cnt_r       <= refdiv_cnt_nxt;
      divided_ref_output <= refout_nxt;
    end
  end

  //----------------------------------------------------------------
  // Reference counter for the phase detector
  //----------------------------------------------------------------
  logic [2:0] rcnt_r;
  logic [2:0] rcnt_nxt;
  logic       rcnt_wrap;

  // A field of zero acts as one so the detector never starves
  assign rcnt_wrap = (rcnt_r + 3'h1 >= cfg_r.ref_count_field);
  assign rcnt_nxt  = (!osc_running || rcnt_wrap) ? 3'h0 : rcnt_r + 3'h1;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rcnt_r       <= 3'h0;
      pfd_ref_tick <= 1'b0;
    end else begin
      rcnt_r       <= rcnt_nxt;
      pfd_ref_tick <= osc_running && rcnt_wrap; // see [RL6]
    end
  end

  //----------------------------------------------------------------
  // Sigma-delta feedback divider
  //----------------------------------------------------------------
  logic [15:0] acc_sum;
  logic [14:0] acc_r;

  // First-order modulator: average ratio = int + frac/32768
  assign acc_sum = {1'b0, acc_r} + {1'b0, cfg_r.fb_frac_field};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      acc_r         <= 15'h0000;
      fb_carry      <= 1'b0;
      fb_divide_now <= 9'h000;
    end else if (!vco_ctrl.osc_power) begin
      acc_r         <= 15'h0000;
      fb_carry      <= 1'b0;
      fb_divide_now <= {1'b0, cfg_r.fb_int_field};
    end else if (pfd_ref_tick) begin
      acc_r         <= acc_sum[14:0];
      fb_carry      <= acc_sum[15];
      // 9 bits hold 255+1 at the top fraction
      fb_divide_now <= {1'b0, cfg_r.fb_int_field} + {8'h00, acc_sum[15]}; // see [RL18] [RL24]
    end else begin
      acc_r         <= acc_r;
      fb_carry      <= 1'b0;
      fb_divide_now <= fb_divide_now;
    end
  end

  //----------------------------------------------------------------
  // Oscillator controls
  //----------------------------------------------------------------
  assign vco_ctrl.osc_power   = cfg_r.synth_enable_bit && ce_r; // see [RL21]
  // Fixed halving, doubled again for the low bands
  assign vco_ctrl.lo_divide   = cfg_r.low_band_halver_bit ? 3'h4 : 3'h2; // see [RL19] [RL22]
  assign vco_ctrl.band_adjust = cfg_r.osc_band_adjust_field;
  assign vco_ctrl.bias        = cfg_r.osc_bias_field;

  //----------------------------------------------------------------
  // Lock detection
  //----------------------------------------------------------------
  logic [2:0] good_cnt_r;
  logic [2:0] good_cnt_nxt;
  logic       err_small;
  logic       err_large;
  logic       dlock_nxt;

  assign err_small    = pfd_err_ns < SDL_LOCK_SET_NS;
  assign err_large    = pfd_err_ns >= SDL_LOCK_CLR_NS;
  assign good_cnt_nxt = !vco_ctrl.osc_power ? 3'h0 :
                        !pfd_err_valid ? good_cnt_r :
                        !err_small ? 3'h0 :
                        (good_cnt_r == SDL_LOCK_COUNT) ? good_cnt_r : good_cnt_r + 3'h1;
  // Set after five good comparisons, hold until a large error or oscillator power-off
  assign dlock_nxt    = !vco_ctrl.osc_power ? 1'b0 :
                        (pfd_err_valid && err_large) ? 1'b0 :
                        (good_cnt_nxt == SDL_LOCK_COUNT) ? 1'b1 : digital_lock; // see [RL11] [RL12]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      good_cnt_r   <= 3'h0;
      digital_lock <= 1'b0;
    end else begin
      good_cnt_r   <= good_cnt_nxt;
      digital_lock <= dlock_nxt;
    end
  end

  // Open-drain analog lock: released when locked, one-cycle pull per comparison
  assign alock_o = 1'b0;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      alock_oe <= 1'b1;
    end else begin
      alock_oe <= !digital_lock || (pfd_ref_tick && !alock_oe); // see [RL13]
    end
  end

  //----------------------------------------------------------------
  // Status multiplexer
  //----------------------------------------------------------------
  logic mux_nxt;

  assign mux_nxt = (cfg_r.status_mux_select_field == SDL_MUX_REGRDY)  ? regulator_ready :
                   (cfg_r.status_mux_select_field == SDL_MUX_DLOCK)   ? digital_lock :
                   (cfg_r.status_mux_select_field == SDL_MUX_ALOCK)   ? !alock_oe :
                   (cfg_r.status_mux_select_field == SDL_MUX_PFD)     ? pfd_ref_tick :
                   (cfg_r.status_mux_select_field == SDL_MUX_FBCARRY) ? fb_carry :
                   1'b0; // see [RL8] [RL9]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status_mux_output_pin <= 1'b0;
    end else begin
      status_mux_output_pin <= mux_nxt;
    end
  end

endmodule

// file: sim/sdl_host_model.sv
// Host model: Wishbone classic master that programs the control block
`timescale 1ns/10ps
module sdl_host_model (
  // Clock and block status
  input  wire logic        clk_sys,
  input  wire logic        regulator_ready,
  // Wishbone answer
  input  wire logic        wb_ack_o,
  input  wire logic [31:0] wb_dat_o,
  // Wishbone request
  output logic             wb_cyc_i,
  output logic             wb_stb_i,
  output logic             wb_we_i,
  output logic [3:0]       wb_adr_i,
  output logic [3:0]       wb_sel_i,
  output logic [31:0]      wb_dat_i
);
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Idle bus at time zero
  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h00000000;
  end
  // One cycle; released lines show inverted data so stale values never match
  task automatic xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    wb_adr_i <= ~adr;
    wb_dat_i <= ~wd;
  endtask
  // Write only once the serial regulator reports ready
  task automatic prog(input logic [3:0] adr, input logic [31:0] wd);
    logic [31:0] rd;
    while (regulator_ready !== 1'b1) @(posedge clk_sys);
    xfer(1'b1, adr, wd, rd);
  endtask
endmodule

// file: sim/sdl_top_assertions.sv
// Port checker for the synthesizer control block
`timescale 1ns/10ps
module sdl_top_assertions
  import sdl_pkg::*;
#(
  parameter int REG_SETTLE_CY = SDL_REG_SETTLE_CY
) (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // Watched ports
  input wire logic       chip_enable,
  input wire logic       pfd_err_valid,
  input wire logic [7:0] pfd_err_ns,
  input wire logic       status_mux_output_pin,
  input wire logic       digital_lock,
  input wire logic       alock_o,
  input wire logic       alock_oe,
  input wire logic       osc_running,
  input wire logic       regulator_ready,
  input wire sdl_vco_t   vco_ctrl
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [15:0] ce_cnt_r;
  // Cycles of chip enable high, saturating so long runs never wrap
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ce_cnt_r <= 16'h0000;
    end else if (!chip_enable) begin
      ce_cnt_r <= 16'h0000;
    end else if (ce_cnt_r != 16'hFFFF) begin
      ce_cnt_r <= ce_cnt_r + 16'h0001;
    end
  end
  // Comparison results that move the lock state
  sequence s_bad_err;
    pfd_err_valid && pfd_err_ns >= SDL_LOCK_CLR_NS;
  endsequence
  sequence s_good_err;
    pfd_err_valid && pfd_err_ns < SDL_LOCK_SET_NS;
  endsequence
  a_lock_clear: assert property (digital_lock ##0 s_bad_err |=> !digital_lock)
    else $error("lock kept after large error");
  a_lock_hold: assert property (digital_lock && vco_ctrl.osc_power &&
      !(pfd_err_valid && pfd_err_ns >= SDL_LOCK_CLR_NS) |=> digital_lock || !vco_ctrl.osc_power)
    else $error("lock lost without large error");
  a_lock_set: assert property ($rose(digital_lock) |->
      $past(pfd_err_valid) && $past(pfd_err_ns) < SDL_LOCK_SET_NS)
    else $error("lock rose without good comparison");
  a_alock_idle: assert property (!digital_lock [*2] |-> alock_oe && !alock_o)
    else $error("analog lock released while unlocked");
  a_alock_narrow: assert property (digital_lock [*3] ##0 alock_oe |=> !alock_oe || !digital_lock)
    else $error("analog lock pulse wider than one cycle");
  a_osc_ce_off: assert property (!chip_enable [*5] |-> !osc_running && !vco_ctrl.osc_power)
    else $error("oscillator on while chip enable low");
  a_ready_ce_drop: assert property ($fell(chip_enable) |-> ##[1:4] !regulator_ready)
    else $error("regulator ready kept after chip enable low");
  a_ready_settle: assert property ($rose(regulator_ready) |-> ce_cnt_r >= REG_SETTLE_CY)
    else $error("regulator ready too early");
  a_ready_reach: assert property (ce_cnt_r == REG_SETTLE_CY + 8 |-> regulator_ready)
    else $error("regulator ready too late");
  a_mux_default: assert property ($rose(regulator_ready) |-> ##[0:2] status_mux_output_pin)
    else $error("status pin not showing regulator ready");
  a_lo_div_set: assert property (vco_ctrl.lo_divide == 3'h2 || vco_ctrl.lo_divide == 3'h4)
    else $error("oscillator divide not two or four");
  c_lock_seen: cover property (s_good_err ##[1:2] $rose(digital_lock));
endmodule

// file: sim/tb_synth_divider_lock_control.sv
// Self-checking bench for the synthesizer control block
`timescale 1ns/10ps
module tb_synth_divider_lock_control;
  import sdl_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int SETTLE = 20;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        chip_enable = 1'b1;
  logic        pfd_err_valid = 1'b0;
  logic [7:0]  pfd_err_ns = 8'h00;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        divided_ref_output, pfd_ref_tick, fb_carry, status_mux_output_pin;
  logic        digital_lock, alock_o, alock_oe, osc_running, regulator_ready;
  logic [8:0]  fb_divide_now;
  sdl_vco_t    vco_ctrl;
  logic        msel = 1'b0;
  int          mismatches = 0;
  int          checks_done = 0;
  wire logic   meas = msel ? pfd_ref_tick : divided_ref_output;
  // Clock, 25 ns period
  always #12.5 clk_sys = ~clk_sys;
  sdl_top #(.REG_SETTLE_CY(SETTLE)) sdl_top_inst (
    .clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chip_enable(chip_enable),
    .pfd_err_valid(pfd_err_valid), .pfd_err_ns(pfd_err_ns),
    .divided_ref_output(divided_ref_output), .pfd_ref_tick(pfd_ref_tick),
    .fb_divide_now(fb_divide_now), .fb_carry(fb_carry),
    .status_mux_output_pin(status_mux_output_pin), .digital_lock(digital_lock),
    .alock_o(alock_o), .alock_oe(alock_oe), .osc_running(osc_running),
    .regulator_ready(regulator_ready), .vco_ctrl(vco_ctrl));
  sdl_host_model sdl_host_model_inst (
    .clk_sys(clk_sys), .regulator_ready(regulator_ready), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i));
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [3:0] adr, input logic [31:0] msk, input logic [31:0] exp);
    logic [31:0] rd;
    sdl_host_model_inst.xfer(1'b0, adr, 32'h00000000, rd);
    chk(rd & msk, exp);
  endtask
  task automatic wait_ready();
    while (regulator_ready !== 1'b1) @(posedge clk_sys);
  endtask
  // Cycles between two rising edges; the first gap is skipped as it may be partial
  task automatic gap(output int n);
    int k, e;
    logic p;
    repeat (2) begin
      e = 0;
      n = 0;
      p = meas;
      for (k = 0; k < 400 && e < 2; k++) begin
        @(posedge clk_sys);
        if (e == 1) n++;
        if (meas === 1'b1 && p === 1'b0) e++;
        p = meas;
      end
    end
  endtask
  task automatic pulse(input logic [7:0] err, input int cnt);
    repeat (cnt) begin
      @(posedge clk_sys);
      pfd_err_valid <= 1'b1;
      pfd_err_ns    <= err;
      @(posedge clk_sys);
      pfd_err_valid <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults();
    logic [31:0] rd;
    sdl_host_model_inst.xfer(1'b1, SDL_OFS_CTRL1, 32'h0000A103, rd);
    wait_ready();
    rd_chk(SDL_OFS_CTRL1, 32'h000001FF, 32'h00000114);
    rd_chk(SDL_OFS_FBDIV, 32'hFFFFFFFF, 32'h000F8000);
    rd_chk(SDL_OFS_STATUS, 32'h0000000F, 32'h0000000D);
    chk(status_mux_output_pin, 1'b1);
    sdl_host_model_inst.prog(4'h2, 32'hFFFFFFFF);
    rd_chk(4'h2, 32'hFFFFFFFF, 32'h00000000);
  endtask
  task automatic t_refdiv();
    int n, k, e;
    msel = 1'b0;
    gap(n);
    chk(n, 8);
    for (k = 1; k < 16; k += 14) begin
      sdl_host_model_inst.prog(SDL_OFS_CTRL1, 32'h0000A110 | 32'(k));
      gap(n);
      chk(n, 2 * k);
    end
    sdl_host_model_inst.prog(SDL_OFS_CTRL1, 32'h0000A110);
    repeat (4) @(posedge clk_sys);
    e = 0;
    for (k = 0; k < 64; k++) begin
      @(posedge clk_sys);
      if (divided_ref_output !== 1'b0) e++;
    end
    chk(e, 0);
  endtask
  task automatic t_rcount();
    int n, r;
    msel = 1'b1;
    for (r = 3; r < 8; r += 4) begin
      sdl_host_model_inst.prog(SDL_OFS_CTRL1, 32'h0000A104 | (32'(r) << 4));
      gap(n);
      chk(n, r);
    end
  endtask
  task automatic t_lock();
    sdl_host_model_inst.prog(SDL_OFS_CTRL0, 32'h00000003);
    chk(vco_ctrl.osc_power, 1'b1);
    pulse(8'h0E, 4);
    pulse(8'h0F, 1);
    pulse(8'h0E, 4);
    chk(digital_lock, 1'b0);
    pulse(8'h0E, 1);
    while (pfd_ref_tick !== 1'b1) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    chk({digital_lock, status_mux_output_pin, alock_oe}, 3'h6);
    pulse(8'h18, 1);
    chk(digital_lock, 1'b1);
    pulse(8'h19, 1);
    chk({digital_lock, status_mux_output_pin, alock_oe}, 3'h1);
  endtask
  task automatic t_fbdiv();
    sdl_host_model_inst.prog(SDL_OFS_FBDIV, 32'h000A0000);
    rd_chk(SDL_OFS_FBDIV, 32'hFFFFFFFF, 32'h000F8000);
    sdl_host_model_inst.prog(SDL_OFS_FBDIV, 32'h007FFFFF);
    rd_chk(SDL_OFS_FBDIV, 32'hFFFFFFFF, 32'h007FFFFF);
    repeat (20) @(posedge clk_sys);
    chk(fb_divide_now, 9'h100);
  endtask
  task automatic t_vco();
    sdl_host_model_inst.prog(SDL_OFS_CTRL1, 32'h0000FE14);
    chk({vco_ctrl.lo_divide, vco_ctrl.band_adjust, vco_ctrl.bias}, 9'h13F);
    chk(osc_running, 1'b0);
    sdl_host_model_inst.prog(SDL_OFS_CTRL1, 32'h0000A114);
    chk({vco_ctrl.lo_divide, osc_running}, 4'h5);
  endtask
  task automatic t_ce();
    sdl_host_model_inst.prog(SDL_OFS_CTRL1, 32'h0000A103);
    @(posedge clk_sys);
    chip_enable <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk({regulator_ready, osc_running, vco_ctrl.osc_power}, 3'h0);
    chip_enable <= 1'b1;
    wait_ready();
    rd_chk(SDL_OFS_CTRL1, 32'h000001FF, 32'h00000114);
    rd_chk(SDL_OFS_CTRL0, 32'hFFFFFFFF, 32'h00000000);
    rd_chk(SDL_OFS_FBDIV, 32'hFFFFFFFF, 32'h000F8000);
    chk(status_mux_output_pin, 1'b1);
  endtask
  task automatic end_sim();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence; reset held for six cycles
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    t_defaults();
    t_refdiv();
    t_rcount();
    t_lock();
    t_fbdiv();
    t_vco();
    t_ce();
    end_sim();
  end
  // Watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (30000) @(posedge clk_sys);
    mismatches++;
    end_sim();
  end
endmodule
bind sdl_top sdl_top_assertions #(.REG_SETTLE_CY(REG_SETTLE_CY)) sdl_top_assertions_inst (
  .clk_sys(clk_sys), .resetn(resetn), .chip_enable(chip_enable),
  .pfd_err_valid(pfd_err_valid), .pfd_err_ns(pfd_err_ns),
  .status_mux_output_pin(status_mux_output_pin), .digital_lock(digital_lock),
  .alock_o(alock_o), .alock_oe(alock_oe), .osc_running(osc_running),
  .regulator_ready(regulator_ready), .vco_ctrl(vco_ctrl));
